/* pkg/bbfc_pkg.sv */
// constants shared by both ends of the burst flow check link
package bbfc_pkg;
    localparam int DW          = 32;
    localparam int CW          = 8;
    localparam int TX_DEPTH    = 16;
    localparam int TX_AW       = 4;
    localparam int TX_HIGH     = 8;
    localparam int RX_DEPTH    = 8;
    localparam int RX_AW       = 3;
    localparam int WW          = DW + 3;
    localparam int BURST_MAX   = 8;
    localparam int USER_BURST  = 4;
    localparam int SER_DIV     = 3;
    localparam int RST_HOLD    = 16;
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_MASK  = 8'h08;
    localparam logic [7:0] A_RXCNT = 8'h0c;
    localparam int C_GO      = 0;
    localparam int C_STALL   = 1;
    localparam int C_CRST    = 2;
    localparam int C_LEN_LO  = 8;
    localparam int C_CHAN_LO = 16;
    localparam int S_TXOVF   = 0;
    localparam int S_TXUNF   = 1;
    localparam int S_BURST   = 2;
    localparam int S_RXERR   = 3;
    localparam int S_RXOVF   = 4;
    localparam int NSTAT     = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0400;
endpackage : bbfc_pkg

/* pkg/bbfc_if.sv */
// segmented_local_bus between the core end and the user packet end
`timescale 1ns/10ps
interface bbfc_if;
    import bbfc_pkg::*;
    logic          core_nrst;
    logic          tx_ena;
    logic [DW-1:0] tx_data;
    logic          tx_sop;
    logic          tx_eop;
    logic [CW-1:0] tx_chan;
    logic          tx_bctlin;
    logic          tx_rdyout;
    logic          tx_ovfout;
    logic          tx_underflow_err;
    logic          tx_burst_err;
    logic          rx_ena;
    logic [DW-1:0] rx_data;
    logic          rx_sop;
    logic          rx_eop;
    logic          rx_errout;
    logic          rx_overflow_err;
    logic          rx_stall;
    modport core (input core_nrst, tx_ena, tx_data, tx_sop, tx_eop, tx_chan, tx_bctlin, rx_stall,
                  output tx_rdyout, tx_ovfout, tx_underflow_err, tx_burst_err,
                  output rx_ena, rx_data, rx_sop, rx_eop, rx_errout, rx_overflow_err);
    modport user (output core_nrst, tx_ena, tx_data, tx_sop, tx_eop, tx_chan, tx_bctlin, rx_stall,
                  input tx_rdyout, tx_ovfout, tx_underflow_err, tx_burst_err,
                  input rx_ena, rx_data, rx_sop, rx_eop, rx_errout, rx_overflow_err);
endinterface : bbfc_if

/* logic/bbfc_core_end.sv */
// core end: transmit buffer with flow checks, receive buffer with packet repair
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module bbfc_core_end
    import bbfc_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    bbfc_if.core               lb,
    output logic               ser_tx_valid,
    output logic [DW-1:0]      ser_tx_data,
    output logic               ser_tx_sop,
    output logic               ser_tx_eop,
    output logic               ser_tx_bctl,
    input  wire logic          ser_rx_valid,
    input  wire logic [DW-1:0] ser_rx_data,
    input  wire logic          ser_rx_sop,
    input  wire logic          ser_rx_eop,
    input  wire logic          lane_check_error
);

    typedef struct packed {
        // transmit direction
        logic [TX_DEPTH-1:0][WW-1:0] tx_mem;
        logic [TX_AW:0]              tx_wp;
        logic [TX_AW:0]              tx_rp;
        logic [1:0]                  div;
        logic                        in_pkt;
        logic                        brst_open;
        logic [CW-1:0]               chan;
        logic [3:0]                  bcnt;
        logic                        ovf;
        logic                        unf;
        logic                        berr;
        logic                        s_valid;
        logic [WW-1:0]               s_word;
        // receive direction
        logic [RX_DEPTH-1:0][WW-1:0] rx_mem;
        logic [RX_AW:0]              rx_wp;
        logic [RX_AW:0]              rx_rp;
        logic                        rx_in_pkt;
        logic                        rx_bad;
        logic                        rx_ovf;
        logic                        r_valid;
        logic [WW-1:0]               r_word;
    } bbfc_core_st_t;

    bbfc_core_st_t st_r;
    bbfc_core_st_t st_nxt;

    // occupancy of a buffer from its pointers
    function automatic logic [TX_AW:0] bbfc_fill(input logic [TX_AW:0] wp, input logic [TX_AW:0] rp);
        bbfc_fill = wp - rp;
    endfunction : bbfc_fill

    logic [TX_AW:0] tx_fill;
    logic [RX_AW:0] rx_fill;
    logic           tick;
    logic           tx_wr;
    logic           tx_full;
    logic           trg_pkt;
    logic           trg_max;
    logic           trg_chan;
    logic           trg_force;
    logic [2:0]     trg_num;
    logic           trg_any;
    logic           rx_full;
    logic           rx_sop_eff;
    logic           rx_bad_now;
    logic           run_nrst;

    // decoded conditions shared by the next state logic
    logic [TX_AW:0] rx_fill_w;
    logic           rx_merge;
    logic           rx_nosop;
    logic           tx_multi;
    logic           tx_sop_in;
    logic           tx_nosop;
    logic           tx_starve;
    logic           rx_drain;

    assign run_nrst = nrst & lb.core_nrst;
    assign tx_fill  = bbfc_fill(st_r.tx_wp, st_r.tx_rp);
    assign rx_fill_w = bbfc_fill({1'b0, st_r.rx_wp}, {1'b0, st_r.rx_rp});
    assign rx_fill  = rx_fill_w[RX_AW:0];
    assign tx_full  = (tx_fill == (TX_AW+1)'(TX_DEPTH));
    assign rx_full  = (rx_fill == (RX_AW+1)'(RX_DEPTH));
    assign tick     = (st_r.div == 2'(SER_DIV - 1));
    assign tx_wr    = lb.tx_ena;
    // the user end stalls the drain to model a slow local bus
    assign rx_drain = rx_fill != '0 && !lb.rx_stall;

    // control word triggers carried by the word written this cycle
    assign trg_pkt   = lb.tx_sop | lb.tx_eop;
    assign trg_max   = (st_r.bcnt == 4'(BURST_MAX - 1));
    assign trg_chan  = !lb.tx_sop && (lb.tx_chan != st_r.chan);
    assign trg_force = lb.tx_bctlin;
    assign trg_num   = 3'(trg_pkt) + 3'(trg_max) + 3'(trg_chan) + 3'(trg_force);
    assign trg_any   = (trg_num != 3'd0);

    // burst rule breaks carried by the same word
    assign tx_multi  = (trg_num > 3'd1);
    assign tx_sop_in = lb.tx_sop & st_r.in_pkt;
    assign tx_nosop  = !lb.tx_sop & !st_r.in_pkt;

    // an open burst finds nothing to send at a serial slot
    assign tx_starve = tick && tx_fill == '0 && st_r.brst_open && !tx_wr;

    // start forced when missing, dropped inside an open packet
    assign rx_sop_eff = !st_r.rx_in_pkt;
    assign rx_merge   = ser_rx_sop & st_r.rx_in_pkt;
    assign rx_nosop   = !ser_rx_sop & !st_r.rx_in_pkt;
    assign rx_bad_now = st_r.rx_bad | lane_check_error | rx_merge | rx_nosop;

    ////////////////////////////////////////////////////////////////////////////
    // next state of both directions
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = tick ? 2'd0 : st_r.div + 2'd1;

        // transmit write side
        if (tx_wr) begin
            if (tx_full) begin
                st_nxt.ovf = 1'b1;
            end else begin
                st_nxt.tx_mem[st_r.tx_wp[TX_AW-1:0]] = {trg_any, lb.tx_sop, lb.tx_eop, lb.tx_data};
                st_nxt.tx_wp = st_r.tx_wp + 1'b1;
            end
            if (tx_multi || tx_sop_in || tx_nosop) begin
                st_nxt.berr = 1'b1;
            end
            // packet and burst tracking
            st_nxt.in_pkt    = !lb.tx_eop;
            st_nxt.brst_open = !(lb.tx_eop || trg_max || trg_force);
            st_nxt.chan      = lb.tx_chan;
            st_nxt.bcnt      = trg_any ? 4'd0 : st_r.bcnt + 4'd1;
        end

        // serial drain at the slower rate
        st_nxt.s_valid = 1'b0;
        if (tick) begin
            if (tx_fill != '0) begin
                st_nxt.s_valid = 1'b1;
                st_nxt.s_word  = st_r.tx_mem[st_r.tx_rp[TX_AW-1:0]];
                st_nxt.tx_rp   = st_r.tx_rp + 1'b1;
            end else if (tx_starve) begin
                st_nxt.unf = 1'b1;
            end
        end

        // receive fill from the serial side
        if (ser_rx_valid) begin
            // full buffer: word dropped, overflow flagged
            if (rx_full) begin
                st_nxt.rx_ovf = 1'b1;
                // a lost word spoils the packet still open
                st_nxt.rx_bad = st_r.rx_in_pkt;
            end else begin
                st_nxt.rx_mem[st_r.rx_wp[RX_AW-1:0]] =
                    {ser_rx_eop & rx_bad_now, rx_sop_eff, ser_rx_eop, ser_rx_data};
                st_nxt.rx_wp = st_r.rx_wp + 1'b1;
                st_nxt.rx_in_pkt = !ser_rx_eop;
                st_nxt.rx_bad = !ser_rx_eop && rx_bad_now;
            end
        end

        // receive drain onto the local bus
        st_nxt.r_valid = 1'b0;
        if (rx_drain) begin
            st_nxt.r_valid = 1'b1;
            st_nxt.r_word  = st_r.rx_mem[st_r.rx_rp[RX_AW-1:0]];
            st_nxt.rx_rp   = st_r.rx_rp + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // whole state in one register, reset by either reset
    always_ff @(posedge ref_clk) begin
        if (!run_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // backpressure once the buffer reaches the high mark
    assign lb.tx_rdyout        = (tx_fill >= (TX_AW+1)'(TX_HIGH));

    // sticky flags, cleared only by either reset
    assign lb.tx_ovfout        = st_r.ovf;
    assign lb.tx_underflow_err = st_r.unf;
    assign lb.tx_burst_err     = st_r.berr;
    assign lb.rx_overflow_err  = st_r.rx_ovf;

    // received words onto the local bus
    assign lb.rx_ena           = st_r.r_valid;
    assign lb.rx_data          = st_r.r_word[DW-1:0];
    assign lb.rx_eop           = st_r.r_valid & st_r.r_word[DW];
    assign lb.rx_sop           = st_r.r_valid & st_r.r_word[DW+1];
    assign lb.rx_errout        = st_r.r_valid & st_r.r_word[DW+2];

    // words towards the serial side
    assign ser_tx_valid        = st_r.s_valid;
    assign ser_tx_data         = st_r.s_word[DW-1:0];
    assign ser_tx_eop          = st_r.s_valid & st_r.s_word[DW];
    assign ser_tx_sop          = st_r.s_valid & st_r.s_word[DW+1];
    assign ser_tx_bctl         = st_r.s_valid & st_r.s_word[DW+2];

endmodule : bbfc_core_end

/* logic/bbfc_user_end.sv */
// user end: packet writer with enhanced scheduling, apb control and status
`timescale 1ns/10ps
module bbfc_user_end
    import bbfc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    bbfc_if.user             lb,
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEND  = 3'b010,
        ST_PAUSE = 3'b100
    } bbfc_tx_st_t;

    typedef struct packed {
        bbfc_tx_st_t       tx_st;
        logic [31:0]       ctrl;
        logic [NSTAT-1:0]  stat;
        logic [NSTAT-1:0]  mask;
        logic [NSTAT-1:0]  lvl;
        logic [15:0]       rx_pkts;
        logic [15:0]       rx_errs;
        logic [31:0]       rdata;
        logic [4:0]        hold;
        logic [7:0]        widx;
        logic [3:0]        bidx;
        logic [7:0]        len;
        logic [CW-1:0]     chan;
        logic [DW-1:0]     seq;
        logic              ena;
        logic              sop;
        logic              eop;
        logic              bctl;
    } bbfc_user_st_t;

    bbfc_user_st_t st_r;
    bbfc_user_st_t st_nxt;

    logic             acc;
    logic             mapped;
    logic             emit;
    logic [7:0]       len_now;
    logic             last;
    logic [NSTAT-1:0] lvl_now;

    assign acc     = psel & penable;
    assign mapped  = (paddr[7:0] == A_CTRL) || (paddr[7:0] == A_STAT) || (paddr[7:0] == A_MASK)
                   || (paddr[7:0] == A_RXCNT);
    assign len_now = (st_r.tx_st == ST_IDLE) ? st_r.ctrl[C_LEN_LO +: 8] : st_r.len;
    assign last    = (st_r.widx + 8'd1 >= len_now);
    assign lvl_now = {lb.rx_overflow_err, 1'b0, lb.tx_burst_err, lb.tx_underflow_err, lb.tx_ovfout};

    // a new burst starts only without backpressure; a started one runs on
    always_comb begin
        emit = 1'b0;
        unique case (st_r.tx_st)
            ST_IDLE:  emit = st_r.ctrl[C_GO] && !lb.tx_rdyout && st_r.hold == '0;
            ST_SEND:  emit = 1'b1;
            ST_PAUSE: emit = !lb.tx_rdyout;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.hold = (st_r.hold != '0) ? st_r.hold - 5'd1 : 5'd0;
        if (st_r.ctrl[C_CRST]) begin
            st_nxt.hold = 5'(RST_HOLD);
        end

        // packet writer
        st_nxt.ena = emit;
        if (emit) begin
            if (st_r.tx_st == ST_IDLE) begin
                st_nxt.len  = (st_r.ctrl[C_LEN_LO +: 8] == 8'd0) ? 8'd1 : st_r.ctrl[C_LEN_LO +: 8];
                st_nxt.chan = st_r.ctrl[C_CHAN_LO +: CW];
            end
            st_nxt.sop  = (st_r.widx == 8'd0);
            st_nxt.eop  = last || len_now == 8'd0;
            // forced control word closes each short burst, never with an end
            st_nxt.bctl = !st_nxt.eop && st_r.bidx == 4'(USER_BURST - 1);
            st_nxt.seq  = st_r.seq + 32'h0000_0001;
            if (st_nxt.eop) begin
                st_nxt.widx  = 8'd0;
                st_nxt.bidx  = 4'd0;
                st_nxt.tx_st = ST_IDLE;
            end else begin
                st_nxt.widx  = st_r.widx + 8'd1;
                st_nxt.bidx  = st_nxt.bctl ? 4'd0 : st_r.bidx + 4'd1;
                st_nxt.tx_st = st_nxt.bctl ? ST_PAUSE : ST_SEND;
            end
        end

        // receive counters
        if (lb.rx_ena && lb.rx_eop) begin
            st_nxt.rx_pkts = st_r.rx_pkts + 16'd1;
            if (lb.rx_errout) begin
                st_nxt.rx_errs = st_r.rx_errs + 16'd1;
            end
        end

        // register access, set wins over clear
        st_nxt.lvl = lvl_now;
        st_nxt.stat = st_r.stat;
        if (acc && pwrite && paddr[7:0] == A_STAT) begin
            st_nxt.stat = st_r.stat & ~pwdata[NSTAT-1:0];
        end
        st_nxt.stat = st_nxt.stat | (lvl_now & ~st_r.lvl);
        st_nxt.stat[S_RXERR] = st_nxt.stat[S_RXERR] | (lb.rx_ena & lb.rx_errout);
        if (acc && pwrite && paddr[7:0] == A_CTRL) begin
            st_nxt.ctrl = pwdata;
        end
        if (acc && pwrite && paddr[7:0] == A_MASK) begin
            st_nxt.mask = pwdata[NSTAT-1:0];
        end
        if (psel && !penable) begin
            unique case (paddr[7:0])
                A_CTRL:  st_nxt.rdata = st_r.ctrl;
                A_STAT:  st_nxt.rdata = {27'h000_0000, st_r.stat};
                A_MASK:  st_nxt.rdata = {27'h000_0000, st_r.mask};
                A_RXCNT: st_nxt.rdata = {st_r.rx_errs, st_r.rx_pkts};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r       <= '0;
            st_r.tx_st <= ST_IDLE;
            st_r.ctrl  <= CTRL_RST;
            st_r.hold  <= 5'(RST_HOLD);
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign pready       = 1'b1;
    assign pslverr      = acc & !mapped;
    assign prdata       = st_r.rdata;
    assign irq          = |(st_r.stat & st_r.mask);
    assign lb.core_nrst = (st_r.hold == '0);
    assign lb.rx_stall  = st_r.ctrl[C_STALL];
    assign lb.tx_ena    = st_r.ena;
    assign lb.tx_data   = st_r.seq;
    assign lb.tx_sop    = st_r.ena & st_r.sop;
    assign lb.tx_eop    = st_r.ena & st_r.eop;
    assign lb.tx_bctlin = st_r.ena & st_r.bctl;
    assign lb.tx_chan   = st_r.chan;

endmodule : bbfc_user_end

/* testbench/bbfc_link_checker.sv */
// concurrent checks on the local bus between the core end and the user end
`timescale 1ns/10ps
module bbfc_link_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic core_nrst,
    input wire logic tx_ena,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire logic tx_bctlin,
    input wire logic tx_rdyout,
    input wire logic tx_ovfout,
    input wire logic tx_underflow_err,
    input wire logic tx_burst_err,
    input wire logic rx_ena,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic rx_errout,
    input wire logic rx_overflow_err
);
    logic tx_open_r;
    logic rx_open_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst || !core_nrst);

    ////////////////////////////////////////////////////////////////////////
    // open burst and open packet trackers
    always_ff @(posedge ref_clk) begin
        if (!nrst || !core_nrst) begin
            tx_open_r <= 1'h0;
            rx_open_r <= 1'h0;
        end else begin
            if (tx_ena) tx_open_r <= !(tx_eop || tx_bctlin);
            if (rx_ena) rx_open_r <= !rx_eop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RST_HOLD: assert property (disable iff (!nrst) $rose(nrst) |-> (!core_nrst) [*8])
        else $error("core reset released too early");
    AST_RDY_CAUSE: assert property ($rose(tx_rdyout) |-> $past(tx_ena))
        else $error("backpressure rose without a write");
    AST_USER_STOP: assert property (tx_ena && !tx_open_r |-> !$past(tx_rdyout))
        else $error("burst started under backpressure");
    AST_BURST_GAP: assert property (tx_open_r |-> tx_ena)
        else $error("gap inside an open burst");
    AST_TRIG_ONE: assert property (tx_ena && tx_bctlin |-> !tx_eop && !tx_sop)
        else $error("forced control word coincides with packet edge");
    AST_OVF_STICKY: assert property (tx_ovfout |=> tx_ovfout)
        else $error("overflow flag dropped");
    AST_UNF_STICKY: assert property (!$fell(tx_underflow_err))
        else $error("underflow flag dropped");
    AST_BERR_STICKY: assert property (tx_burst_err |=> tx_burst_err [*2])
        else $error("burst error flag dropped");
    AST_RX_ERR: assert property (rx_errout |-> rx_ena && rx_eop)
        else $error("receive error off the closing word");
    AST_RX_SOP: assert property (rx_ena |-> rx_sop == !rx_open_r)
        else $error("receive packet framing broken");
    AST_RXOVF_STICKY: assert property ($rose(rx_overflow_err) |=> rx_overflow_err [*4])
        else $error("receive overflow flag dropped");
endmodule : bbfc_link_checker

/* testbench/bbfc_tb.sv */
// testbench: user end and core end joined over the local bus
`timescale 1ns/10ps
module bbfc_tb;
    import bbfc_pkg::*;
    logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, rd, ctrl, prev;
    logic        s_valid, s_sop, s_eop, s_lerr, t_valid, t_sop, t_eop, t_bctl, er, seen, chk_on;
    logic [31:0] s_data, t_data;
    int          miscompares, comparisons, pos, elen, words, lens[5];

    bbfc_if lb();
    bbfc_if bad_lb();
    bbfc_core_end bbfc_core_end_i (.ref_clk(ref_clk), .nrst(nrst), .lb(lb), .ser_tx_valid(t_valid),
        .ser_tx_data(t_data), .ser_tx_sop(t_sop), .ser_tx_eop(t_eop), .ser_tx_bctl(t_bctl),
        .ser_rx_valid(s_valid), .ser_rx_data(s_data), .ser_rx_sop(s_sop), .ser_rx_eop(s_eop),
        .lane_check_error(s_lerr));
    bbfc_core_end bbfc_core_end_b_i (.ref_clk(ref_clk), .nrst(nrst), .lb(bad_lb), .ser_tx_valid(),
        .ser_tx_data(), .ser_tx_sop(), .ser_tx_eop(), .ser_tx_bctl(), .ser_rx_valid(s_valid),
        .ser_rx_data(s_data), .ser_rx_sop(s_sop), .ser_rx_eop(s_eop), .lane_check_error(s_lerr));
    bbfc_user_end bbfc_user_end_i (.ref_clk(ref_clk), .nrst(nrst), .lb(lb), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    bbfc_link_checker bbfc_link_checker_i (.ref_clk(ref_clk), .nrst(nrst), .core_nrst(lb.core_nrst),
        .tx_ena(lb.tx_ena), .tx_sop(lb.tx_sop), .tx_eop(lb.tx_eop), .tx_bctlin(lb.tx_bctlin),
        .tx_rdyout(lb.tx_rdyout), .tx_ovfout(lb.tx_ovfout), .tx_underflow_err(lb.tx_underflow_err),
        .tx_burst_err(lb.tx_burst_err), .rx_ena(lb.rx_ena), .rx_sop(lb.rx_sop), .rx_eop(lb.rx_eop),
        .rx_errout(lb.rx_errout), .rx_overflow_err(lb.rx_overflow_err));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic print_verdict;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= {24'h00_0000, a};
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    // serial receive words, one every third cycle
    task automatic sr(input int n, input logic sop, input logic eop, input logic le);
        for (int i = 0; i < n; i++) begin
            s_valid <= 1'h1;
            s_data  <= $urandom;
            s_sop   <= sop && i == 0;
            s_eop   <= eop && i == n - 1;
            s_lerr  <= le;
            @(posedge ref_clk);
            s_valid <= 1'h0;
            s_lerr  <= 1'h0;
            repeat (2) @(posedge ref_clk);
        end
    endtask : sr

    // consecutive writes into the rule-breaking core end
    task automatic bwn(input int n, input logic sopall);
        for (int i = 0; i < n; i++) begin
            bad_lb.tx_ena  <= 1'h1;
            bad_lb.tx_sop  <= sopall || i == 0;
            bad_lb.tx_data <= $urandom;
            @(posedge ref_clk);
            if (bad_lb.tx_rdyout === 1'h1) seen = 1'h1;
        end
        bad_lb.tx_ena <= 1'h0;
    endtask : bwn

    task automatic brst;
        bad_lb.core_nrst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        bad_lb.core_nrst <= 1'h1;
        @(posedge ref_clk);
    endtask : brst

    ////////////////////////////////////////////////////////////////////////
    // serial transmit monitor, expectations from packet position
    always @(posedge ref_clk) begin
        if (t_valid === 1'h1 && chk_on) begin
            chk1(t_sop, pos == 0);
            chk1(t_eop, pos == elen - 1);
            chk1(t_bctl, pos == 0 || pos == elen - 1 || pos % USER_BURST == USER_BURST - 1);
            if (pos > 0) chk(t_data, prev + 32'h0000_0001);
            prev = t_data;
            words++;
            pos = (pos == elen - 1) ? 0 : pos + 1;
        end
    end

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        {nrst, psel, penable, pwrite, s_valid, s_sop, s_eop, s_lerr, chk_on, seen} = '0;
        {paddr, pwdata, s_data, prev} = '0;
        {bad_lb.core_nrst, bad_lb.tx_ena, bad_lb.tx_sop, bad_lb.tx_eop, bad_lb.tx_bctlin} = '0;
        {bad_lb.rx_stall, bad_lb.tx_data, bad_lb.tx_chan} = '0;
        void'($urandom(29618));
        lens = '{0, 4, 5, 8, 1 + $urandom_range(11)};
        repeat (4) @(posedge ref_clk);
        nrst <= 1'h1;
        repeat (20) @(posedge ref_clk);
        rdc(A_CTRL, CTRL_RST);
        rdc(A_STAT, 32'h0000_0000);
        rdc(A_MASK, 32'h0000_0000);
        rdc(8'h10, 32'h0000_0000);
        chk1(er, 1'h1);
        $display("register test done");
        foreach (lens[i]) begin
            elen = (lens[i] == 0) ? 1 : lens[i];
            ctrl = 32'h0000_0001 | (lens[i] << C_LEN_LO) | ($urandom_range(255) << C_CHAN_LO);
            pos = 0;
            chk_on = 1'h1;
            apb(1'h1, A_CTRL, ctrl);
            repeat (300) @(posedge ref_clk);
            apb(1'h1, A_CTRL, ctrl & 32'hffff_fffe);
            repeat (150) @(posedge ref_clk);
            chk_on = 1'h0;
            chk(pos, 0);
        end
        chk1(words > 0, 1'h1);
        rdc(A_STAT, 32'h0000_0000);
        $display("transmit test done");
        apb(1'h1, A_CTRL, CTRL_RST);
        apb(1'h1, A_MASK, 32'h0000_0008);
        repeat (3) sr(1 + $urandom_range(4), 1'h1, 1'h1, 1'h0);
        sr(3, 1'h1, 1'h1, 1'h1);
        sr(2, 1'h1, 1'h0, 1'h0);
        sr(3, 1'h1, 1'h1, 1'h0);
        repeat (30) @(posedge ref_clk);
        rdc(A_RXCNT, 32'h0002_0005);
        rdc(A_STAT, 32'h0000_0008);
        chk1(irq, 1'h1);
        apb(1'h1, A_MASK, 32'h0000_0000);
        chk1(irq, 1'h0);
        apb(1'h1, A_STAT, 32'h0000_0008);
        rdc(A_STAT, 32'h0000_0000);
        $display("receive test done");
        apb(1'h1, A_CTRL, CTRL_RST | 32'h0000_0002);
        sr(14, 1'h1, 1'h1, 1'h0);
        chk1(lb.rx_overflow_err, 1'h1);
        rdc(A_STAT, 32'h0000_0010);
        apb(1'h1, A_CTRL, CTRL_RST);
        sr(2, 1'h1, 1'h1, 1'h0);
        repeat (40) @(posedge ref_clk);
        rdc(A_RXCNT, 32'h0003_0006);
        apb(1'h1, A_CTRL, CTRL_RST | 32'h0000_0004);
        @(posedge ref_clk);
        chk1(lb.core_nrst, 1'h0);
        apb(1'h1, A_CTRL, CTRL_RST);
        repeat (30) @(posedge ref_clk);
        chk1(lb.rx_overflow_err, 1'h0);
        $display("receive overflow test done");
        brst();
        chk1(bad_lb.tx_rdyout, 1'h0);
        bwn(1, 1'h0);
        repeat (12) @(posedge ref_clk);
        chk1(bad_lb.tx_underflow_err, 1'h1);
        brst();
        bwn(2, 1'h1);
        repeat (3) @(posedge ref_clk);
        chk1(bad_lb.tx_burst_err, 1'h1);
        brst();
        seen = 1'h0;
        bwn(30, 1'h0);
        @(posedge ref_clk);
        chk1(seen, 1'h1);
        chk1(bad_lb.tx_ovfout, 1'h1);
        $display("fault test done");
        print_verdict();
    end
endmodule : bbfc_tb
